// >>> logic/osm_channel.v
// one channel of the retriggerable rc-timed one-shot control machine
`timescale 1ns/1ps
`include "osm_defines.vh"
// one instance per channel, nothing shared between instances
module osm_channel
(
    input wire clk_i,
    input wire rst_n_i,
    input wire rise_i,
    input wire fall_n_i,
    input wire stop_in_n,
    input wire cmp_low_i,
    input wire cmp_high_i,
    output wire pulse_o,
    output wire pulse_n_o,
    output wire timing_node_o,
    output wire timing_node_oe_o,
    output wire cmp_en_o,
    output wire [`OSM_TCNT_W-1:0] saved_cnt_o
);
localparam [10:0] ST_READY = 11'h001;
localparam [10:0] ST_DISCH = 11'h002;
localparam [10:0] ST_MON = 11'h004;
localparam [10:0] ST_TDEC = 11'h008;
localparam [10:0] ST_CDEC = 11'h010;
localparam [10:0] ST_INC = 11'h020;
localparam [10:0] ST_RST = 11'h040;
localparam [10:0] ST_SAVE = 11'h080;
localparam [10:0] ST_DRST = 11'h100;
localparam [10:0] ST_DLY = 11'h200;
localparam [10:0] ST_DINC = 11'h400;

reg [10:0] state_r;
reg [10:0] state_nxt;
reg [`OSM_TCNT_W-1:0] tcnt_r;
reg [`OSM_TCNT_W-1:0] saved_r;
reg [`OSM_CYC_W-1:0] cyc_r;
reg [`OSM_REP_W-1:0] rep_r;
reg ovf_r;
reg rise_d_r;
reg fall_d_r;
reg stop_d_r;
wire rise_s;
wire fall_s;
wire stop_s;
wire low_s;
wire high_s;
wire trig;
wire tick;
wire run;
wire clr_async;

////////////////////////////////////////////////////////////////////////////
// synchronisers for edge inputs and comparators
osm_sync #(.RST_VAL(1'b0)) u_rise (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(rise_i), .q_o(rise_s));
osm_sync #(.RST_VAL(1'b1)) u_fall (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(fall_n_i), .q_o(fall_s));
// power-on idle level is high so that reset release gives no false edge
osm_sync #(.RST_VAL(1'b1)) u_stop (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(stop_in_n), .q_o(stop_s));
osm_sync #(.RST_VAL(1'b0)) u_low (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(cmp_low_i), .q_o(low_s));
osm_sync #(.RST_VAL(1'b0)) u_high (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(cmp_high_i), .q_o(high_s));

// clear acts with no clock, together with power-on reset
assign clr_async = rst_n_i & stop_in_n;

////////////////////////////////////////////////////////////////////////////
// edge memory; rises of stop after clear count as trigger
always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        rise_d_r <= 1'b0;
        fall_d_r <= 1'b1;
        stop_d_r <= 1'b1;
    end
    else
    begin
        rise_d_r <= rise_s;
        fall_d_r <= fall_s;
        stop_d_r <= stop_s;
    end
end

// each edge only counts with the other two inputs at their gating levels
assign trig = (rise_s & ~rise_d_r & ~fall_s & stop_s)
    | (~fall_s & fall_d_r & rise_s & stop_s)
    | (stop_s & ~stop_d_r & rise_s & ~fall_s);

// clocks off only in ready; comparators on only in discharge, monitor and tdec
assign run = (state_r != ST_READY);
assign cmp_en_o = (state_r == ST_DISCH) || (state_r == ST_MON) ||
    (state_r == ST_TDEC);

// cycle 1 fast undivided, later cycles slow with divider 2**(cyc-2)
osm_clkgen u_clk
(
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(run),
    .slow_i(cyc_r != `OSM_CYC_FIRST),
    .div_sel_i((cyc_r > `OSM_CYC_FIRST) ? cyc_r - 4'h2 : 4'h0),
    .tick_o(tick)
);

////////////////////////////////////////////////////////////////////////////
// next-state: trigger wins over task-complete in monitor, inc, save and the delay states; clear is handled by reset
always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_READY:
            if (trig)
                state_nxt = ST_DISCH;
        ST_DISCH:
            if (low_s)
                state_nxt = ST_MON;
        ST_MON:
            if (trig)
                state_nxt = ST_DISCH;
            else if (high_s)
                state_nxt = ST_TDEC;
        ST_TDEC:
            if (ovf_r || tcnt_r > `OSM_TCNT_OVF)
                state_nxt = ST_CDEC;
            else
                state_nxt = ST_SAVE;
        ST_CDEC:
            if (cyc_r <= `OSM_CYC_LAST)
                state_nxt = ST_INC;
            else
                state_nxt = ST_SAVE;
        ST_INC:
            if (trig)
                state_nxt = ST_DISCH;
            else
                state_nxt = ST_RST;
        ST_RST:
            state_nxt = ST_DISCH;
        ST_SAVE:
            if (trig)
                state_nxt = ST_DISCH;
            else
                state_nxt = ST_DRST;
        ST_DRST:
            if (trig)
                state_nxt = ST_DISCH;
            else
                state_nxt = ST_DLY;
        ST_DLY:
            if (trig)
                state_nxt = ST_DISCH;
            else if (tcnt_r >= saved_r)
                state_nxt = ST_DINC;
        ST_DINC:
            if (trig)
                state_nxt = ST_DISCH;
            else if (rep_r + 11'h001 >= `OSM_REP_TOTAL)
                state_nxt = ST_READY;
            else
                state_nxt = ST_DRST;
        default:
            state_nxt = ST_READY;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// state and counters; clear resets everything asynchronously
always @(posedge clk_i or negedge clr_async)
begin
    if (!clr_async)
    begin
        state_r <= ST_READY;
        tcnt_r <= {`OSM_TCNT_W{1'b0}};
        saved_r <= {`OSM_TCNT_W{1'b0}};
        cyc_r <= `OSM_CYC_FIRST;
        rep_r <= {`OSM_REP_W{1'b0}};
        ovf_r <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        // timer: held reset in ready; saturates and flags overflow
        if (state_r == ST_READY || state_r == ST_RST ||
            state_r == ST_DRST)
        begin
            tcnt_r <= {`OSM_TCNT_W{1'b0}};
            if (state_r != ST_DRST)
                ovf_r <= 1'b0;
        end
        else if ((state_r == ST_DISCH || state_r == ST_MON ||
            state_r == ST_DLY) && tick)
        begin
            if (tcnt_r > `OSM_TCNT_OVF)
                ovf_r <= 1'b1;
            else
                tcnt_r <= tcnt_r + 13'h0001;
        end
        if (state_r == ST_READY)
        begin
            cyc_r <= `OSM_CYC_FIRST;
            rep_r <= {`OSM_REP_W{1'b0}};
        end
        if (state_r == ST_INC)
        begin
            cyc_r <= cyc_r + 4'h1;
            rep_r <= rep_r + 11'h001;
        end
        if (state_r == ST_SAVE)
        begin
            // measurement pass counts toward the 1024 total
            rep_r <= rep_r + 11'h001;
            if (ovf_r || tcnt_r > `OSM_TCNT_OVF)
                saved_r <= `OSM_TCNT_OVF;
            else
                saved_r <= tcnt_r;
        end
        if (state_r == ST_DINC)
            rep_r <= rep_r + 11'h001;
        if (trig && state_r != ST_READY)
            ovf_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// pulse high outside ready; node low only while discharging
assign pulse_o = (state_r != ST_READY);
assign pulse_n_o = (state_r == ST_READY);
assign timing_node_o = (state_r != ST_DISCH);
assign timing_node_oe_o = (state_r != ST_MON);
assign saved_cnt_o = saved_r;
endmodule

// >>> inc/osm_defines.vh
// constants for the one-shot rc measurement state machine
`ifndef OSM_DEFINES_VH
`define OSM_DEFINES_VH
`define OSM_TCNT_W 13
`define OSM_TCNT_OVF 13'h1000
`define OSM_CYC_W 4
`define OSM_CYC_LAST 4'hb
`define OSM_CYC_FIRST 4'h1
`define OSM_REP_W 11
`define OSM_REP_TOTAL 11'h400
`define OSM_DIV_W 10
`define OSM_FAST_DIV 6'h04
`define OSM_SLOW_DIV 6'h28
`define OSM_PRE_W 6
`endif

// >>> logic/osm_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module osm_sync
#(
    parameter RST_VAL = 1'b0
)
(
    input wire clk_i,
    input wire rst_n_i,
    input wire d_i,
    output reg q_o
);
reg s1_r;
reg s2_r;
reg s3_r;

////////////////////////////////////////////////////////////////////////////
// first stage feeds only the second; change counts once 2 and 3 agree
always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        s1_r <= RST_VAL;
        s2_r <= RST_VAL;
        s3_r <= RST_VAL;
        q_o <= RST_VAL;
    end
    else
    begin
        s1_r <= d_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r)
            q_o <= s3_r;
    end
end
endmodule

// >>> logic/osm_clkgen.v
// counter clock tick generator: prescaled oscillator plus binary divider
`timescale 1ns/1ps
`include "osm_defines.vh"
module osm_clkgen
(
    input wire clk_i,
    input wire rst_n_i,
    input wire run_i,
    input wire slow_i,
    input wire [`OSM_CYC_W-1:0] div_sel_i,
    output wire tick_o
);
reg [`OSM_PRE_W-1:0] pre_r;
reg [`OSM_DIV_W-1:0] div_r;
wire [`OSM_PRE_W-1:0] pre_top;
wire pre_tick;
wire [`OSM_DIV_W-1:0] div_mask;

// oscillators modelled as prescaled system clock
assign pre_top = slow_i ? `OSM_SLOW_DIV : `OSM_FAST_DIV;
assign pre_tick = run_i && (pre_r == pre_top - 6'h01);
// divider of 2**div_sel: all low bits set ends a period
assign div_mask = ~({`OSM_DIV_W{1'b1}} << div_sel_i);
assign tick_o = pre_tick && ((div_r & div_mask) == div_mask);

////////////////////////////////////////////////////////////////////////////
// counters held reset while stopped, saves power in the ready state
always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        pre_r <= {`OSM_PRE_W{1'b0}};
        div_r <= {`OSM_DIV_W{1'b0}};
    end
    else if (!run_i)
    begin
        pre_r <= {`OSM_PRE_W{1'b0}};
        div_r <= {`OSM_DIV_W{1'b0}};
    end
    else if (pre_tick)
    begin
        pre_r <= {`OSM_PRE_W{1'b0}};
        div_r <= div_r + {{(`OSM_DIV_W-1){1'b0}}, 1'b1};
    end
    else
    begin
        pre_r <= pre_r + {{(`OSM_PRE_W-1){1'b0}}, 1'b1};
    end
end
endmodule

// >>> bench/osm_channel_properties.sv
// concurrent checks on the ports of one one-shot channel
`timescale 1ns/1ps
module osm_channel_properties
(
    input wire clk_i,
    input wire rst_n_i,
    input wire rise_i,
    input wire fall_n_i,
    input wire stop_in_n,
    input wire pulse_o,
    input wire pulse_n_o,
    input wire timing_node_o,
    input wire timing_node_oe_o,
    input wire cmp_en_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
////////////////////////////////////////////////////////////////////////////
a_pulse_pair: assert property (pulse_n_o == !pulse_o)
    else $error("pulse outputs not complementary");
a_clear_idle: assert property (!stop_in_n |-> !pulse_o)
    else $error("pulse high while clear held");
a_ready_node: assert property (!pulse_o |-> timing_node_oe_o && timing_node_o)
    else $error("node not driven high in idle");
a_ready_cmp_off: assert property (!pulse_o |-> !cmp_en_o)
    else $error("comparators on in idle");
a_monitor_float: assert property (!timing_node_oe_o |-> pulse_o && cmp_en_o)
    else $error("node released outside monitor");
a_discharge_low: assert property
    (timing_node_oe_o && !timing_node_o |-> pulse_o && cmp_en_o)
    else $error("node pulled low outside discharge");
// trigger edges only count with the other inputs at their gating levels
a_rise_start: assert property ($rose(rise_i) && !fall_n_i && stop_in_n
    |-> ##[1:8] (pulse_o || !stop_in_n))
    else $error("rise edge gave no pulse");
a_fall_start: assert property ($fell(fall_n_i) && rise_i && stop_in_n
    |-> ##[1:8] (pulse_o || !stop_in_n))
    else $error("fall edge gave no pulse");
a_stop_start: assert property ($rose(stop_in_n) && rise_i && !fall_n_i
    |-> ##[1:8] (pulse_o || !stop_in_n))
    else $error("clear release gave no pulse");
endmodule
bind osm_channel osm_channel_properties u_props (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .rise_i(rise_i), .fall_n_i(fall_n_i),
    .stop_in_n(stop_in_n), .pulse_o(pulse_o), .pulse_n_o(pulse_n_o),
    .timing_node_o(timing_node_o), .timing_node_oe_o(timing_node_oe_o),
    .cmp_en_o(cmp_en_o));

// >>> bench/osm_rc_model.sv
// behavioural rc network and threshold comparators for one channel
`timescale 1ns/1ps
module osm_rc_model
(
    input wire clk_i,
    input wire node_i,
    input wire oe_i,
    input wire [15:0] chg_i,
    output wire cmp_low_o,
    output wire cmp_high_o
);
integer v = 0;
// node level in clock steps; linear charge is a simplification
always @(posedge clk_i)
begin
    if (oe_i && node_i)
        v <= chg_i;
    else if (oe_i)
        v <= 0;
    else if (v < chg_i)
        v <= v + 1;
end
assign cmp_low_o = (v == 0);
assign cmp_high_o = (v >= chg_i);
endmodule

// >>> bench/test_osm_channel.sv
// self-checking bench for one rc-timed one-shot channel
`timescale 1ns/1ps
`include "osm_defines.vh"
module test_osm_channel;
reg clk_i = 1'b0;
reg rst_n_i = 1'b0;
reg rise_i = 1'b0;
reg fall_n_i = 1'b1;
reg stop_in_n = 1'b1;
reg [15:0] chg = 16'h0018;
wire cmp_low, cmp_high, pulse_o, pulse_n_o, node, oe, cmp_en_o;
wire [`OSM_TCNT_W-1:0] saved;
wire [2:0] mon = {oe, cmp_en_o, pulse_o};
integer miscompares = 0;
integer checks_done = 0;
integer n, k;
always #12.5 clk_i = ~clk_i;
osm_channel u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rise_i(rise_i),
    .fall_n_i(fall_n_i), .stop_in_n(stop_in_n), .cmp_low_i(cmp_low),
    .cmp_high_i(cmp_high), .pulse_o(pulse_o), .pulse_n_o(pulse_n_o),
    .timing_node_o(node), .timing_node_oe_o(oe), .cmp_en_o(cmp_en_o),
    .saved_cnt_o(saved));
osm_rc_model u_rc (.clk_i(clk_i), .node_i(node), .oe_i(oe), .chg_i(chg),
    .cmp_low_o(cmp_low), .cmp_high_o(cmp_high));
////////////////////////////////////////////////////////////////////////////
task summarize;
begin
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
end
endtask
// inputs move 2 ns after the edge, never on it
task step(input integer c);
begin
    repeat (c) @(posedge clk_i);
    #2;
end
endtask
task chk_bit(input got, input exp, input [8*12:1] msg);
begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: %0s", $time, msg);
    end
end
endtask
task chk_rng(input [31:0] got, input [31:0] lo, input [31:0] hi);
begin
    checks_done = checks_done + 1;
    if (^got === 1'bx || got < lo || got > hi)
    begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: %0d out of range", $time, got);
    end
end
endtask
// bounded wait; n keeps the cycles spent for pulse length checks
task wait_lvl(input integer sel, input lvl, input integer bound);
begin
    n = 0;
    while (mon[sel] !== lvl && n < bound)
    begin
        step(1);
        n = n + 1;
    end
    if (n >= bound)
    begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: wait ran out", $time);
        summarize;
    end
end
endtask
// kind 0 rise edge, 1 fall edge, 2 clear release; gates preset under clear
task fire(input integer kind);
begin
    stop_in_n = 1'b0;
    rise_i = (kind != 0);
    fall_n_i = (kind == 1);
    step(4);
    stop_in_n = (kind != 2);
    step(4);
    rise_i = 1'b1;
    fall_n_i = 1'b0;
    stop_in_n = 1'b1;
end
endtask
////////////////////////////////////////////////////////////////////////////
task test_idle;
begin
    chk_bit(pulse_o, 1'b0, "idle pulse");
    chk_bit(oe & node, 1'b1, "idle node");
    chk_bit(cmp_en_o, 1'b0, "idle cmp");
    $display("idle test done");
end
endtask
task test_kinds;
begin
    for (k = 0; k < 3; k = k + 1)
    begin
        fire(k);
        wait_lvl(0, 1'b1, 12);
        chk_bit(node, 1'b0, "discharge");
        wait_lvl(2, 1'b0, 40);
        chk_bit(pulse_o, 1'b1, "monitor");
        stop_in_n = 1'b0;
        #1;
        chk_bit(pulse_n_o, 1'b1, "clear");
        step(2);
    end
    $display("trigger kinds test done");
end
endtask
// charge too long for the fast clock: second cycle must settle it
task test_ovf;
begin
    chg = 16'h4268;
    fire(0);
    wait_lvl(1, 1'b1, 12);
    wait_lvl(1, 1'b0, 20000);
    wait_lvl(1, 1'b1, 12);
    wait_lvl(1, 1'b0, 20000);
    step(1);
    chk_rng(saved, 415, 440);
    stop_in_n = 1'b0;
    step(2);
    $display("overflow test done");
end
endtask
task test_full;
begin
    chg = 16'h0018;
    fire(0);
    wait_lvl(1, 1'b1, 12);
    wait_lvl(1, 1'b0, 100);
    step(1);
    chk_rng(saved, 3, 12);
    rise_i = 1'b0;
    step(4);
    rise_i = 1'b1;
    wait_lvl(1, 1'b1, 12);
    chk_bit(pulse_o, 1'b1, "retrigger");
    wait_lvl(0, 1'b0, 65000);
    chk_rng(n, 4000 * saved, 1024 * (4 * saved + 12));
    chk_bit(oe & node, 1'b1, "back idle");
    $display("full pulse test done");
end
endtask
initial
begin
    repeat (16) @(posedge clk_i);
    #2;
    rst_n_i = 1'b1;
    step(8);
    test_idle;
    test_kinds;
    test_ovf;
    test_full;
    summarize;
end
endmodule
